/* File: verilog/tpp_pkg.sv */
package tpp_pkg;
  // data and address widths
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 5;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL   = 5'h00;
  localparam logic [AW-1:0] OFS_PERIOD = 5'h04;
  localparam logic [AW-1:0] OFS_DUTY   = 5'h08;
  localparam logic [AW-1:0] OFS_COUNT  = 5'h0C;
  localparam logic [AW-1:0] OFS_STAT   = 5'h10;
  localparam logic [AW-1:0] OFS_CLR    = 5'h14;
  localparam logic [AW-1:0] OFS_EN     = 5'h18;
  localparam logic [AW-1:0] OFS_OUT    = 5'h1C;

  // timer_control_reg field positions
  localparam int unsigned CTL_START_LO = 0;
  localparam int unsigned CTL_START_HI = 1;
  localparam int unsigned CTL_ONESHOT  = 2;
  localparam int unsigned CTL_INITLVL  = 3;
  localparam int unsigned CTL_MODE     = 4;
  localparam int unsigned CTL_CKS_LO   = 5;
  localparam int unsigned CTL_CKS_HI   = 7;
  localparam int unsigned CTL_W        = 8;
  localparam logic [CTL_W-1:0] CTL_RST = 8'h00;

  // start_control_field encodings
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_SW   = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;

  // interrupt status bit positions
  localparam int unsigned IRQ_DUTY = 0;
  localparam int unsigned IRQ_PER  = 1;
  localparam int unsigned IRQ_W    = 2;

  // source clock divider
  localparam int unsigned DIV_W = 7;
  localparam int unsigned CKS_W = 3;

  // trigger noise rejection, times in periods of fc
  localparam int unsigned MCLK_HZ        = 10_000_000;
  localparam int unsigned FC_HZ          = 10_000_000;
  localparam int unsigned NOISE_REJ_FC   = 4;
  localparam int unsigned NOISE_GUAR_FC  = 12;
  localparam int unsigned REJ_CYC_RAW    = (NOISE_REJ_FC * MCLK_HZ) / FC_HZ;
  localparam int unsigned REJ_CYC        = (REJ_CYC_RAW < 1) ? 1 : REJ_CYC_RAW;
  localparam int unsigned FLT_W          = 4;
  localparam logic [FLT_W-1:0] REJ_LAST  = REJ_CYC[FLT_W-1:0];

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } tpp_state_t;
endpackage : tpp_pkg

/* File: verilog/tpp_core_if.sv */
`timescale 1ns/1ns
interface tpp_core_if;
  import tpp_pkg::*;
  logic [CKS_W-1:0] cks;
  logic             tick;
  logic             trg;
  logic             rise;
  logic             fall;
  modport pre  (input cks, output tick);
  modport flt  (input trg, output rise, output fall);
  modport core (output cks, output trg, input tick, input rise, input fall);
endinterface : tpp_core_if

/* File: verilog/tpp_prescale.sv */
`timescale 1ns/1ns
module tpp_prescale (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // source clock select and tick
  tpp_core_if.pre  pif
);
  import tpp_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;
  logic             tick_q;

  // tick period is 2**cks mclk cycles; divider free-runs so the rate never jitters
  assign mask = DIV_W'((1 << pif.cks) - 1);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= ((div_q & mask) == mask);
    end
  end

  assign pif.tick = tick_q;
endmodule : tpp_prescale

/* File: verilog/tpp_trig_filter.sv */
`timescale 1ns/1ns
module tpp_trig_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // trigger level in, filtered edges out
  tpp_core_if.flt  fif
);
  import tpp_pkg::*;

  logic             lvl_q;
  logic [FLT_W-1:0] cnt_q;
  logic             rise_q;
  logic             fall_q;

  // a new level is taken only after REJ_CYC+1 equal samples, so glitches of REJ_CYC die
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lvl_q  <= 1'b0;
      cnt_q  <= '0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (fif.trg == lvl_q) begin
        cnt_q <= '0;
      end else if (cnt_q == REJ_LAST) begin
        lvl_q  <= fif.trg;
        cnt_q  <= '0;
        rise_q <= fif.trg;
        fall_q <= ~fif.trg;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign fif.rise = rise_q;
  assign fif.fall = fall_q;

  property p_rise_stable;
    @(posedge mclk) disable iff (sys_rst)
    fif.rise |-> ($past(fif.trg, 1) && $past(fif.trg, 2) && $past(fif.trg, 3) && $past(fif.trg, 4)
                 && $past(fif.trg, 5));
  endproperty
  a_rise_stable: assert property (p_rise_stable) else $error("rise taken from a short pulse");

  property p_fall_stable;
    @(posedge mclk) disable iff (sys_rst)
    fif.fall |-> (!$past(fif.trg, 1) && !$past(fif.trg, 2) && !$past(fif.trg, 3) && !$past(fif.trg, 4)
                 && !$past(fif.trg, 5));
  endproperty
  a_fall_stable: assert property (p_fall_stable) else $error("fall taken from a short pulse");
endmodule : tpp_trig_filter

/* File: verilog/tpp_top.sv */
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// - pulse mode counts up on the selected internal source clock to shape pulses
// - start field picks software start or timer input pin edge start
// - oneshot bit 0 gives continuous pulses, 1 gives a single pulse
// - duty match inverts output, raises interrupt, counter keeps counting
// - continuous period match inverts output, interrupts, clears counter, continues
// - start field written 00 stops counter, output holds its last level
// - oneshot period match inverts, interrupts, clears start field, stops, holds level
// - pin is inverse of output flip-flop; initial level 0 gives high pin
// - reset clears the output flip-flop
// - stopped at inverted level, initial-level write loads its inverse
// - external start uses rising or falling pin edge as selected
// - pin pulses of 4/fc or less are rejected; 12/fc always detected
module tpp_top (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [tpp_pkg::AW-1:0] reg_addr,
  input  wire logic [tpp_pkg::DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [tpp_pkg::DW-1:0] reg_rdata,
  // pins
  input  wire logic              timer_input_pin,
  output logic                   programmable_pulse_out_pin,
  // interrupt
  output logic                   timer_match_irq
);
  import tpp_pkg::*;

  tpp_core_if cif ();

  tpp_state_t        state_q;
  logic [CTL_W-1:0]  timer_control_reg_q;
  logic [DW-1:0]     period_compare_reg_q;
  logic [DW-1:0]     duty_compare_reg_q;
  logic [DW-1:0]     count_q;
  logic              output_flip_flop_q;
  logic              phase_q;
  logic [IRQ_W-1:0]  stat_q;
  logic [IRQ_W-1:0]  irq_en_q;
  logic [DW-1:0]     rdata_q;

  logic [1:0]        start_control_field;
  logic              oneshot_select_bit;
  logic              initial_level_bit;
  logic              timer_mode_field;
  logic              wr_ctrl;
  logic [1:0]        wr_start;
  logic              step;
  logic              hit_duty;
  logic              hit_per;
  logic              trig_hit;

  assign start_control_field = timer_control_reg_q[CTL_START_HI:CTL_START_LO];
  assign oneshot_select_bit  = timer_control_reg_q[CTL_ONESHOT];
  assign initial_level_bit   = timer_control_reg_q[CTL_INITLVL];
  assign timer_mode_field    = timer_control_reg_q[CTL_MODE];
  assign wr_ctrl             = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_start            = reg_wdata[CTL_START_HI:CTL_START_LO];

  // submodules: source clock divider and noise-filtered trigger edges
  assign cif.cks = timer_control_reg_q[CTL_CKS_HI:CTL_CKS_LO];
  assign cif.trg = timer_input_pin;

  tpp_prescale u_pre (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pif     (cif)
  );

  tpp_trig_filter u_flt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .fif     (cif)
  );

  // count events, only on a source clock tick while running
  assign step     = (state_q == ST_RUN) && cif.tick;
  assign hit_duty = step && timer_mode_field && (count_q == duty_compare_reg_q);
  assign hit_per  = step && (count_q == period_compare_reg_q);
  assign trig_hit = (start_control_field == START_RISE) ? cif.rise : cif.fall;

  // control register; a software write beats the oneshot auto-clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_control_reg_q <= CTL_RST;
    end else if (wr_ctrl) begin
      timer_control_reg_q <= reg_wdata[CTL_W-1:0];
    end else if (hit_per && oneshot_select_bit) begin
      timer_control_reg_q[CTL_START_HI:CTL_START_LO] <= START_STOP;
    end
  end

  // compare registers, written freely; safe ordering is up to software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      period_compare_reg_q <= '0;
      duty_compare_reg_q   <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_PERIOD) begin
        period_compare_reg_q <= reg_wdata;
      end
      if (reg_addr == OFS_DUTY) begin
        duty_compare_reg_q <= reg_wdata;
      end
    end
  end

  // run sequencer: idle, armed for a pin edge, running
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (wr_ctrl && (wr_start == START_STOP)) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_ctrl && (wr_start == START_SW)) begin
            state_q <= ST_RUN;
          end else if (wr_ctrl) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (trig_hit) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (hit_per && oneshot_select_bit && !wr_ctrl) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // up-counter; cleared while not running so every start begins at zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (state_q != ST_RUN) begin
      count_q <= '0;
    end else if (hit_per) begin
      count_q <= '0;
    end else if (step) begin
      count_q <= count_q + 1'b1;
    end
  end

  // output flip-flop; phase remembers an odd number of toggles since the last timer mode,
  // which is why an initial-level write after such a stop lands inverted
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      output_flip_flop_q <= 1'b0;
      phase_q            <= 1'b0;
    end else if (hit_duty || (hit_per && timer_mode_field)) begin
      output_flip_flop_q <= ~output_flip_flop_q;
      phase_q            <= ~phase_q;
    end else if (wr_ctrl && (state_q != ST_RUN)) begin
      if (!reg_wdata[CTL_MODE]) begin
        phase_q <= 1'b0;
      end else begin
        output_flip_flop_q <= reg_wdata[CTL_INITLVL] ^ phase_q;
      end
    end
  end

  assign programmable_pulse_out_pin = ~output_flip_flop_q;

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((reg_wr && (reg_addr == OFS_CLR)) ? reg_wdata[IRQ_W-1:0] : '0))
                | {hit_per, hit_duty};
    end
  end

  // interrupt enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_en_q <= '0;
    end else if (reg_wr && (reg_addr == OFS_EN)) begin
      irq_en_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign timer_match_irq = |(stat_q & irq_en_q);

  // read data, valid the cycle after the strobe; unmapped and write-only read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:   rdata_q <= DW'(timer_control_reg_q);
        OFS_PERIOD: rdata_q <= period_compare_reg_q;
        OFS_DUTY:   rdata_q <= duty_compare_reg_q;
        OFS_COUNT:  rdata_q <= count_q;
        OFS_STAT:   rdata_q <= DW'(stat_q);
        OFS_EN:     rdata_q <= DW'(irq_en_q);
        OFS_OUT:    rdata_q <= DW'({state_q, programmable_pulse_out_pin, output_flip_flop_q});
        default:    rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_duty_toggle;
    hit_duty && !hit_per |=> (output_flip_flop_q != $past(output_flip_flop_q)) && stat_q[IRQ_DUTY];
  endproperty
  a_duty_toggle: assert property (p_duty_toggle) else $error("duty match did not toggle");

  property p_cont_wrap;
    hit_per && timer_mode_field && !oneshot_select_bit && !wr_ctrl
      |=> (count_q == '0) && (state_q == ST_RUN) && (output_flip_flop_q != $past(output_flip_flop_q));
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("continuous period match wrong");

  property p_oneshot_stop;
    hit_per && oneshot_select_bit && !wr_ctrl
      |=> (state_q == ST_IDLE) && (start_control_field == START_STOP) && stat_q[IRQ_PER];
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("oneshot did not stop");

  property p_hold_idle;
    (state_q == ST_IDLE) && !wr_ctrl |=> $stable(output_flip_flop_q);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("output moved while stopped");

  property p_sw_stop;
    wr_ctrl && (wr_start == START_STOP) |=> (state_q == ST_IDLE) ##1 (count_q == '0);
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("stop write ignored");

  property p_count_step;
    step && !hit_per |=> count_q == $past(count_q) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_count_hold;
    (state_q == ST_RUN) && !cif.tick |=> $stable(count_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without tick");

  property p_arm_wait;
    (state_q == ST_ARMED) && !trig_hit && !wr_ctrl |=> state_q == ST_ARMED;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("started without trigger edge");

  property p_edge_start;
    (state_q == ST_ARMED) && trig_hit && !wr_ctrl |=> state_q == ST_RUN;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("trigger edge missed");

  property p_init_level;
    wr_ctrl && (state_q != ST_RUN) && reg_wdata[CTL_MODE] && !phase_q
      |=> programmable_pulse_out_pin == ~$past(reg_wdata[CTL_INITLVL]);
  endproperty
  a_init_level: assert property (p_init_level) else $error("initial level not applied");

  property p_reset_ff;
    sys_rst |=> !output_flip_flop_q && programmable_pulse_out_pin;
  endproperty
  a_reset_ff: assert property (disable iff (1'b0) p_reset_ff) else $error("reset level wrong");

  property p_phase_inv;
    wr_ctrl && (state_q != ST_RUN) && reg_wdata[CTL_MODE] && phase_q
      |=> programmable_pulse_out_pin == $past(reg_wdata[CTL_INITLVL]);
  endproperty
  a_phase_inv: assert property (p_phase_inv) else $error("inverted initial level not applied");

  property p_irq_duty;
    hit_duty && irq_en_q[IRQ_DUTY] && !(reg_wr && (reg_addr == OFS_EN)) |=> timer_match_irq;
  endproperty
  a_irq_duty: assert property (p_irq_duty) else $error("duty match raised no interrupt");

  property p_irq_per;
    hit_per && irq_en_q[IRQ_PER] && !(reg_wr && (reg_addr == OFS_EN)) |=> timer_match_irq;
  endproperty
  a_irq_per: assert property (p_irq_per) else $error("period match raised no interrupt");

  property p_stat_sticky;
    !(reg_wr && (reg_addr == OFS_CLR)) |=> (stat_q & $past(stat_q)) == $past(stat_q);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost without clear");
endmodule : tpp_top

/* File: sim/tpp_load.sv */
`timescale 1ns/1ns
// pulse load: a passive sink on the pulse pin that counts the edges it sees
module tpp_load (
  // clock
  input  wire logic        mclk,
  // driven pin
  input  wire logic        pin,
  // edges observed so far, only differences are meaningful
  output int unsigned      n_edge
);
  bit last_q;
  // sampled on the clock so the count follows what a synchronous load would see
  always_ff @(posedge mclk) begin
    last_q <= pin;
    if (last_q != pin) begin
      n_edge <= n_edge + 1;
    end
  end
endmodule : tpp_load

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import tpp_pkg::*;
  logic          mclk;
  logic          sys_rst;
  logic          reg_wr;
  logic          reg_rd;
  logic          tin;
  logic          pin;
  logic          irq;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] reg_rdata;
  logic [DW-1:0] d;
  int unsigned   n_edge;
  int unsigned   e0;
  int            n_mismatch = 0;
  int            num_checks = 0;
  int            n;
  int            duty;
  int            per;
  int            q[$];

  tpp_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_input_pin(tin), .programmable_pulse_out_pin(pin),
    .timer_match_irq(irq));
  tpp_load load (.mclk(mclk), .pin(pin), .n_edge(n_edge));

  // free-running clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // one-cycle write, taken at the second edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // cycles until the pulse pin changes, bounded so a dead output cannot hang the run
  task automatic wait_tog(output int c);
    logic l;
    l = pin;
    c = 0;
    while (pin === l) begin
      @(posedge mclk);
      #1 c++;
      if (c > 2000) begin
        n_mismatch++;
        results();
      end
    end
  endtask : wait_tog

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : idle

  // continuous pulses at one clock select; first interval skipped since divider phase is free
  task automatic run_cont(input int s);
    duty = 1 + $urandom % 8;
    per = duty + 4 + $urandom % 5;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CTRL, DW'(16'h0010 | (s << 5)));
    wr(OFS_PERIOD, DW'(per));
    wr(OFS_DUTY, DW'(duty));
    wr(OFS_CLR, 16'h0003);
    wr(OFS_EN, 16'h0003);
    wr(OFS_CTRL, DW'(16'h0011 | (s << 5)));
    chk(pin, 1'b1);
    repeat (2) begin
      q.push_back((per - duty) << s);
      q.push_back((duty + 1) << s);
    end
    e0 = n_edge;
    wait_tog(n);
    while (q.size() > 0) begin
      wait_tog(n);
      chk(DW'(n), DW'(q.pop_front()));
    end
    wr(OFS_CTRL, DW'(16'h0010 | (s << 5)));
    idle(3 * (per << s));
    chk(pin, 1'b0);
    chk(DW'(n_edge - e0), 16'h0005);
    rd(OFS_STAT, d);
    chk(d, 16'h0003);
    chk(irq, 1'b1);
    wr(OFS_EN, 16'h0001);
    chk(irq, 1'b1);
    wr(OFS_EN, 16'h0000);
    chk(irq, 1'b0);
    wr(OFS_EN, 16'h0003);
    wr(OFS_CLR, 16'h0003);
    chk(irq, 1'b0);
    rd(OFS_STAT, d);
    chk(d, 16'h0000);
    // stopped at the opposite level, so the written level lands inverted
    wr(OFS_CTRL, DW'(16'h0018 | (s << 5)));
    chk(pin, 1'b1);
  endtask : run_cont

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    tin = 1'b0;
    void'($urandom(32'h82AC5BC7));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, d);
    chk(d, 16'h0000);
    rd(OFS_OUT, d);
    chk(d, 16'h0006);
    chk(irq, 1'b0);
    rd(5'h02, d);
    chk(d, 16'h0000);
    rd(OFS_CLR, d);
    chk(d, 16'h0000);
    run_cont(0);
    run_cont(2);
    // one-shot with low start level after a timer-mode reinitialisation
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CTRL, 16'h001C);
    chk(pin, 1'b0);
    wr(OFS_PERIOD, DW'(per));
    wr(OFS_DUTY, DW'(duty));
    wr(OFS_CTRL, 16'h001D);
    wait_tog(n);
    chk(pin, 1'b1);
    wait_tog(n);
    chk(DW'(n), DW'(per - duty));
    idle(3 * per);
    chk(pin, 1'b0);
    rd(OFS_CTRL, d);
    chk(d, 16'h001C);
    rd(OFS_OUT, d);
    chk(d, 16'h0005);
    // rising-edge start: a 4-cycle glitch is ignored, a long level starts the count
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CTRL, 16'h0012);
    rd(OFS_OUT, d);
    chk(d, 16'h000A);
    @(posedge mclk);
    tin <= 1'b1;
    repeat (4) @(posedge mclk);
    tin <= 1'b0;
    idle(12);
    rd(OFS_OUT, d);
    chk(d, 16'h000A);
    @(posedge mclk);
    tin <= 1'b1;
    idle(12);
    rd(OFS_OUT, d);
    chk(DW'(d[4:2]), 16'h0004);
    rd(OFS_COUNT, d);
    chk(DW'(d <= per), 16'h0001);
    wr(OFS_CTRL, 16'h0010);
    // falling-edge start
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CTRL, 16'h0013);
    @(posedge mclk);
    tin <= 1'b0;
    idle(12);
    rd(OFS_OUT, d);
    chk(DW'(d[4:2]), 16'h0004);
    wr(OFS_CTRL, 16'h0010);
    // timer mode: period matches still count and interrupt, but the pin never moves
    wr(OFS_CLR, 16'h0003);
    wr(OFS_CTRL, 16'h0001);
    e0 = n_edge;
    idle(3 * per);
    rd(OFS_STAT, d);
    chk(d, 16'h0002);
    chk(irq, 1'b1);
    chk(DW'(n_edge - e0), 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    results();
  end
endmodule : tb_top
